// File: inc/instr_decode_pkg.sv
/*
  Constants and carriers for the servo instruction code decoder.
  Assumes one clock domain and a parameter store outside this block.
*/
package instr_decode_pkg;

  // ************************************************************
  // Code classes and field positions
  // ************************************************************
  localparam logic [7:0] class_param_commit = 8'h83;
  localparam logic [7:0] class_pos_write    = 8'h84;
  localparam int         class_msb          = 15;
  localparam int         class_lsb          = 8;
  localparam int         index_msb          = 7;
  localparam int         index_lsb          = 0;
  localparam int         pos_entries        = 255;

  // ************************************************************
  // Answer codes
  // ************************************************************
  localparam logic [7:0] ecode_none      = 8'h00;
  localparam logic [7:0] ecode_bad_code  = 8'h01;
  localparam logic [7:0] ecode_range     = 8'h02;
  localparam logic [7:0] ecode_value     = 8'h03;
  localparam logic [7:0] ecode_half_seq  = 8'h04;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] rst_word   = 16'h0000;
  localparam logic [7:0]  rst_index  = 8'h00;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [15:0] code;
    logic [15:0] data;
    logic        upper;
  } instr_req_t;

  typedef struct packed {
    logic        err;
    logic [7:0]  ecode;
  } instr_resp_t;

  typedef struct packed {
    logic [7:0]  index;
    logic [15:0] value;
  } nv_write_t;

endpackage

// File: logic/servo_instruction_code_decoder.sv
/*
  Instruction code decoder: parameter commit to nonvolatile storage and
  point-table position writes into an internal table.
  Assumes the parameter store answers a read combinationally, in the same cycle the number
  is presented, and that requests are synchronous to clock.
*/
// Behaviour
// - Codes 8301h..83FFh commit the RAM value of that parameter to nonvolatile storage.
// - Low two hex digits of the code give the parameter or entry number.
// - Commit code beyond the write range limit, or value out of range, answers an error.
// - Codes 8401h..84FFh store position data for entries 1..255 in volatile table.
module servo_instruction_code_decoder (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // Instruction request from the network side
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire instr_decode_pkg::instr_req_t req,
  input  wire logic [7:0]                   write_range_limit_param,
  // Answer
  output logic                              resp_valid,
  output instr_decode_pkg::instr_resp_t     resp,
  // Parameter store lookup
  output logic [7:0]                        param_rd_index,
  input  wire logic [15:0]                  param_value,
  input  wire logic [15:0]                  param_lo,
  input  wire logic [15:0]                  param_hi,
  // Nonvolatile write
  output logic                              nv_wr,
  output instr_decode_pkg::nv_write_t       nv_data,
  // Point table read
  input  wire logic [7:0]                   pos_rd_index,
  output logic [31:0]                       pos_rd_data
);

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [0:0] {st_idle, st_lookup} phase_t;

  typedef struct packed {
    phase_t                         phase;
    logic [7:0]                     index;
    logic                           pend_valid;
    logic [7:0]                     pend_index;
    logic [15:0]                    pend_lower;
    logic                           resp_valid;
    instr_decode_pkg::instr_resp_t  resp;
    logic                           nv_wr;
    instr_decode_pkg::nv_write_t    nv;
    logic [31:0]                    rd_data;
  } state_t;

  state_t st_q;
  state_t st_d;

  // Volatile table; not reset, contents lost with power anyway
  logic [31:0] pos_mem [1:instr_decode_pkg::pos_entries];
  logic        pos_we;
  logic [7:0]  pos_widx;
  logic [31:0] pos_wdata;

  logic [7:0]  req_class;
  logic [7:0]  req_index;

  assign req_class = req.code[instr_decode_pkg::class_msb:instr_decode_pkg::class_lsb];
  assign req_index = req.code[instr_decode_pkg::index_msb:instr_decode_pkg::index_lsb];

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_d            = st_q;
    st_d.resp_valid = 1'b0;
    st_d.nv_wr      = 1'b0;
    pos_we          = 1'b0;
    pos_widx        = req_index;
    pos_wdata       = {req.data, st_q.pend_lower};
    if (pos_rd_index == instr_decode_pkg::rst_index) begin
      st_d.rd_data = 32'h00000000;
    end else begin
      st_d.rd_data = pos_mem[pos_rd_index];
    end
    case (st_q.phase)
      st_idle: begin
        if (req_valid) begin
          st_d.resp_valid = 1'b1;
          st_d.resp       = '{err: 1'b0, ecode: instr_decode_pkg::ecode_none};
          if (req_class == instr_decode_pkg::class_param_commit &&
              req_index != instr_decode_pkg::rst_index) begin
            if (req_index > write_range_limit_param) begin
              st_d.resp = '{err: 1'b1, ecode: instr_decode_pkg::ecode_range};
            end else begin
              // Answer waits for the store lookup
              st_d.resp_valid = 1'b0;
              st_d.index      = req_index;
              st_d.phase      = st_lookup;
            end
          end else if (req_class == instr_decode_pkg::class_pos_write &&
                       req_index != instr_decode_pkg::rst_index) begin
            if (!req.upper) begin
              // Lower half only held; table untouched until upper arrives
              st_d.pend_valid = 1'b1;
              st_d.pend_index = req_index;
              st_d.pend_lower = req.data;
            end else if (st_q.pend_valid && st_q.pend_index == req_index) begin
              pos_we          = 1'b1;
              st_d.pend_valid = 1'b0;
            end else begin
              // Upper without matching lower would tear the position
              st_d.pend_valid = 1'b0;
              st_d.resp = '{err: 1'b1, ecode: instr_decode_pkg::ecode_half_seq};
            end
          end else begin
            st_d.resp = '{err: 1'b1, ecode: instr_decode_pkg::ecode_bad_code};
          end
        end
      end
      st_lookup: begin
        st_d.resp_valid = 1'b1;
        st_d.phase      = st_idle;
        if (param_value < param_lo || param_value > param_hi) begin
          st_d.resp = '{err: 1'b1, ecode: instr_decode_pkg::ecode_value};
        end else begin
          st_d.resp  = '{err: 1'b0, ecode: instr_decode_pkg::ecode_none};
          st_d.nv_wr = 1'b1;
          st_d.nv    = '{index: st_q.index, value: param_value};
        end
      end
      default: begin
        st_d.phase = st_idle;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= '{phase:      st_idle,
                index:      instr_decode_pkg::rst_index,
                pend_valid: 1'b0,
                pend_index: instr_decode_pkg::rst_index,
                pend_lower: instr_decode_pkg::rst_word,
                resp_valid: 1'b0,
                resp:       '{err: 1'b0, ecode: instr_decode_pkg::ecode_none},
                nv_wr:      1'b0,
                nv:         '{index: instr_decode_pkg::rst_index,
                              value: instr_decode_pkg::rst_word},
                rd_data:    32'h00000000};
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clock) begin
    if (pos_we) begin
      pos_mem[pos_widx] <= pos_wdata;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign req_ready      = (st_q.phase == st_idle);
  assign resp_valid     = st_q.resp_valid;
  assign resp           = st_q.resp;
  assign param_rd_index = st_q.index;
  assign nv_wr          = st_q.nv_wr;
  assign nv_data        = st_q.nv;
  assign pos_rd_data    = st_q.rd_data;

  // ************************************************************
  // Checks
  // ************************************************************
  AST_COMMIT_FOLLOWS: assert property (
    @(posedge clock) disable iff (rst)
    (req_valid && req_ready && req_class == 8'h83 && req_index != 8'h00 &&
     req_index <= write_range_limit_param)
    |=> (param_rd_index == $past(req_index)) ##1 (resp_valid && (nv_wr || resp.err)))
  else $error("commit not answered two cycles after request");

  AST_NV_INDEX: assert property (
    @(posedge clock) disable iff (rst)
    nv_wr |-> (nv_data.index == $past(param_rd_index) && nv_data.value == $past(param_value)))
  else $error("nonvolatile write carries wrong index or value");

  AST_LIMIT_ERR: assert property (
    @(posedge clock) disable iff (rst)
    (req_valid && req_ready && req_class == 8'h83 && req_index > write_range_limit_param)
    |=> (resp_valid && resp.err && resp.ecode == 8'h02 && !nv_wr) ##1 !nv_wr)
  else $error("code beyond limit not refused");

  AST_VALUE_ERR: assert property (
    @(posedge clock) disable iff (rst)
    (st_q.phase == st_lookup && (param_value < param_lo || param_value > param_hi))
    |=> (resp.err && resp.ecode == 8'h03 && !nv_wr))
  else $error("out of range value committed");

  AST_POS_PAIR: assert property (
    @(posedge clock) disable iff (rst)
    pos_we |-> (req.upper && st_q.pend_valid && st_q.pend_index == req_index))
  else $error("table written without a matching lower half");

  AST_POS_READBACK: assert property (
    @(posedge clock) disable iff (rst)
    (pos_we && pos_rd_index == pos_widx) ##1 $stable(pos_rd_index)
    |=> (pos_rd_data == $past(pos_wdata, 2)))
  else $error("stored position not read back");

endmodule

// File: tb/param_store_model.sv
/*
  Parameter store stand-in: value and limits for the presented number.
  Assumes the decoder samples the answer in the same cycle as the number.
*/
module param_store_model (
  // Lookup
  input  wire logic [7:0] param_rd_index,
  output logic [15:0]     param_value,
  output logic [15:0]     param_lo,
  output logic [15:0]     param_hi
);
  timeunit 1ns;
  timeprecision 1ns;
  // Value tracks the number, so numbers below 2 or above 1ah fall out of range
  always_comb begin
    param_value = {8'h00, param_rd_index};
    param_lo    = 16'h0002;
    param_hi    = 16'h001a;
  end
endmodule

// File: tb/tb_servo_instruction_code_decoder.sv
/*
  Self-checking bench for the instruction code decoder.
  Assumes the parameter store model answers within the lookup cycle.
*/
module tb_servo_instruction_code_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_ready;
  instr_decode_pkg::instr_req_t req = '0;
  logic [7:0] limit = 8'h20;
  logic resp_valid;
  instr_decode_pkg::instr_resp_t resp;
  logic [7:0] rd_idx;
  logic [15:0] pv, plo, phi;
  logic nv_wr;
  instr_decode_pkg::nv_write_t nv_data;
  logic [7:0] pos_rd_index = 8'h00;
  logic [31:0] pos_rd_data;
  int mismatches = 0;
  int n_compared = 0;
  always #25 clock = ~clock;
  servo_instruction_code_decoder dut (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .write_range_limit_param(limit),
    .resp_valid(resp_valid), .resp(resp), .param_rd_index(rd_idx), .param_value(pv),
    .param_lo(plo), .param_hi(phi), .nv_wr(nv_wr), .nv_data(nv_data),
    .pos_rd_index(pos_rd_index), .pos_rd_data(pos_rd_data));
  param_store_model store (.param_rd_index(rd_idx), .param_value(pv), .param_lo(plo),
    .param_hi(phi));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Callers send the lower half before the upper half, except the lone upper half that probes ecode 04
  task automatic send(input logic [15:0] c, input logic [15:0] d, input logic u,
                      input logic [7:0] ec, input int lat);
    int n;
    @(posedge clock);
    req_valid <= 1'b1;
    req.code <= c;
    req.data <= d;
    req.upper <= u;
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    if (lat == 2) chk("ready", {31'd0, req_ready}, 32'd0);
    for (n = 1; n <= 8; n++) begin
      if (n > 1) @(posedge clock);
      if (n > 1) #1;
      if (resp_valid === 1'b1) break;
    end
    if (n > 8) begin
      chk("answer", 32'd0, 32'd1);
      give_verdict();
    end
    chk("latency", n, lat);
    chk("ecode", {24'd0, resp.ecode}, {24'd0, ec});
    chk("err", {31'd0, resp.err}, {31'd0, ec != 8'h00});
    chk("nv_wr", {31'd0, nv_wr}, {31'd0, ec == 8'h00 && c[15:8] == 8'h83});
    if (nv_wr === 1'b1) chk("nv_data", {8'd0, nv_data}, {8'd0, c[7:0], 8'h00, c[7:0]});
  endtask
  task automatic rd_pos(input logic [7:0] i, input logic [31:0] exp);
    @(posedge clock);
    pos_rd_index <= i;
    @(posedge clock);
    @(posedge clock);
    #1;
    chk("pos", pos_rd_data, exp);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_commit();
    send(16'h8313, 16'h0000, 1'b0, 8'h00, 2);
    send(16'h8302, 16'h0000, 1'b0, 8'h00, 2);
    $display("test commit done");
  endtask
  task automatic t_errors();
    logic [15:0] c[7] = '{16'h8500, 16'h8300, 16'h8400, 16'h8321, 16'h8320, 16'h831b, 16'h8301};
    logic [7:0] e[7] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h03, 8'h03};
    int l[7] = '{1, 1, 1, 1, 2, 2, 2};
    for (int k = 0; k < 7; k++) send(c[k], 16'h0000, 1'b0, e[k], l[k]);
    // Limit is live: boundary on both sides of a lowered limit
    @(posedge clock);
    limit <= 8'h12;
    send(16'h8313, 16'h0000, 1'b0, 8'h02, 1);
    send(16'h8312, 16'h0000, 1'b0, 8'h00, 2);
    @(posedge clock);
    limit <= 8'h20;
    $display("test errors done");
  endtask
  task automatic t_position();
    // Table is not reset, so fill the entry before probing a lone lower half
    send(16'h84ff, 16'h2222, 1'b0, 8'h00, 1);
    send(16'h84ff, 16'habcd, 1'b1, 8'h00, 1);
    rd_pos(8'hff, 32'habcd2222);
    send(16'h84ff, 16'h1111, 1'b0, 8'h00, 1);
    rd_pos(8'hff, 32'habcd2222);
    send(16'h84ff, 16'h5555, 1'b1, 8'h00, 1);
    rd_pos(8'hff, 32'h55551111);
    send(16'h84ff, 16'h9999, 1'b1, 8'h04, 1);
    rd_pos(8'hff, 32'h55551111);
    // Commit between halves must not drop the pending lower half
    send(16'h8401, 16'h0777, 1'b0, 8'h00, 1);
    send(16'h8313, 16'h0000, 1'b0, 8'h00, 2);
    send(16'h8401, 16'h0888, 1'b1, 8'h00, 1);
    rd_pos(8'h01, 32'h08880777);
    $display("test position done");
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (20) @(posedge clock);
    chk("ready_rst", {31'd0, req_ready}, 32'd1);
    chk("valid_rst", {31'd0, resp_valid}, 32'd0);
    rst <= 1'b0;
    t_commit();
    t_errors();
    t_position();
    give_verdict();
  end
endmodule
